// ---- core/lcw_pkg.sv ----
// shared constants for the lcd ram write path and its serial link
package lcw_pkg;
	// timing of the link clock made by the master end
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCL_PERIOD_NS = 2560;
	localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	// slave address: fixed upper five bits, two strap bits below
	localparam logic [4:0] SLAVE_ADDR_HI = 5'h0f;

	// display memory geometry
	localparam int         NUM_COLS  = 101;
	localparam int         NUM_BANKS = 17;
	localparam int         MEM_WORDS = NUM_COLS * NUM_BANKS;
	localparam logic [6:0] COL_LAST  = 7'h64;
	localparam logic [4:0] BANK_LAST = 5'h10;
	localparam int         PART_BANK_BITS = 6;

	// control byte and command byte fields
	localparam int CTRL_CO_BIT  = 7;
	localparam int CTRL_RS_BIT  = 6;
	localparam int CMD_SETX_BIT = 7;
	localparam int CMD_SETY_BIT = 6;
	localparam int CMD_FUNC_BIT = 5;
	localparam int FUNC_V_BIT   = 1;
	localparam int FUNC_MX_BIT  = 0;

	// values after reset and fixed answers
	localparam logic [7:0] TEMP_RESET  = 8'h00;
	localparam logic [7:0] NO_READBACK = 8'hff;
endpackage

// ---- core/lcw_if.sv ----
// two-wire link between the bus master end and the lcd driver end
`timescale 1ns/10ps
interface lcw_if;
	logic scl;
	logic mst_sda_o;
	logic mst_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic sda_line;

	// wired-and with pull-up: any enabled low driver wins
	assign sda_line = ~((~mst_sda_oe_n & ~mst_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

	modport device (input scl, input sda_line, output dev_sda_o, output dev_sda_oe_n);
	modport host (output scl, output mst_sda_o, output mst_sda_oe_n, input sda_line);
endinterface

// ---- core/lcw_ram_writer.sv ----
// write address counter and display memory with an independent refresh read port
`timescale 1ns/10ps
module lcw_ram_writer #(
	parameter int COLS  = lcw_pkg::NUM_COLS,
	parameter int BANKS = lcw_pkg::NUM_BANKS
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic       set_x,
	input  wire logic       set_y,
	input  wire logic [6:0] ptr_val,
	input  wire logic       mirror,
	input  wire logic       vertical,
	input  wire logic [4:0] rd_bank,
	input  wire logic [6:0] rd_col,
	output logic      [7:0] rd_data_q
);
	logic [7:0]  mem_q [COLS*BANKS];
	logic [6:0]  x_q;
	logic [6:0]  x_d;
	logic [4:0]  y_q;
	logic [4:0]  y_d;
	logic [6:0]  phys_col;
	logic [10:0] wr_idx;
	logic [10:0] rd_idx;
	logic [7:0]  wr_word;
	logic        x_end;
	logic        y_end;

	// mirror only changes where new bytes land, stored data stays put
	assign phys_col = mirror ? 7'(lcw_pkg::COL_LAST - x_q) : x_q;
	assign wr_idx   = 11'(y_q * 11'(COLS) + 11'(phys_col));
	assign rd_idx   = 11'(rd_bank * 11'(COLS) + 11'(rd_col));
	// the partial bank keeps only its six low bits
	assign wr_word  = (y_q == lcw_pkg::BANK_LAST) ?
		{{(8-lcw_pkg::PART_BANK_BITS){1'b0}}, wr_data[lcw_pkg::PART_BANK_BITS-1:0]} : wr_data;
	assign x_end    = (x_q == lcw_pkg::COL_LAST);
	assign y_end    = (y_q == lcw_pkg::BANK_LAST);

	// pointer advance after each stored byte
	always_comb begin
		x_d = x_q;
		y_d = y_q;
		if (set_x) begin
			x_d = ptr_val;
		end else if (set_y) begin
			y_d = ptr_val[4:0];
		end else if (wr_en && vertical) begin
			y_d = y_end ? 5'h00 : 5'(y_q + 5'h01);
			if (y_end) begin
				x_d = x_end ? 7'h00 : 7'(x_q + 7'h01);
			end
		end else if (wr_en) begin
			x_d = x_end ? 7'h00 : 7'(x_q + 7'h01);
			if (x_end) begin
				y_d = y_end ? 5'h00 : 5'(y_q + 5'h01);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			x_q <= 7'h00;
			y_q <= 5'h00;
		end else begin
			x_q <= x_d;
			y_q <= y_d;
		end
	end

	// memory contents are not reset; the panel shows garbage until written
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_idx] <= wr_word;
		end
	end

	// refresh read runs every cycle, untouched by bus traffic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= mem_q[rd_idx];
		end
	end
endmodule // lcw_ram_writer

// ---- core/lcw_device.sv ----
// lcd driver end: two-wire slave, control byte decoder, ram write path
// Notes on behaviour
// - host programs only columns 0-100, banks 0-16
// - memory is 17 banks of 101 bytes
// - bank 16 stores only six low bits
// - mirror affects later writes, never stored data
// - vertical mode: bank steps, wraps, column advances
// - horizontal mode: column steps, wraps, bank advances
// - after last location both pointers wrap
// - low reset initialises everything except the display memory contents
// - strap pins give address bits 0 and 1
// - drive on data output, sample on input
// - slave only, never drives clock
// - start: data falls while clock high
// - stop: data rises while clock high
// - data changes while clock high are conditions
// - master starts only on idle bus; lcw_host also takes a start request after a byte sent without stop
// - temperature byte readable through serial interface
// - display refresh independent of bus traffic
// - answers to addresses 01111 plus straps
// - control byte: bit7 continuation, bit6 select
// - select set: data stored, pointer advances
`timescale 1ns/10ps
module lcw_device (
	input  wire logic       clk,
	input  wire logic       rst_b,
	lcw_if.device           bus,
	input  wire logic       addr_select_lsb,
	input  wire logic       addr_select_msb,
	input  wire logic [7:0] temp_reading,
	input  wire logic [4:0] disp_rd_bank,
	input  wire logic [6:0] disp_rd_col,
	output logic      [7:0] disp_rd_data_q,
	output logic            horizontal_mirror_q,
	output logic            vertical_q
);
	typedef enum logic [2:0] {LCW_IDLE, LCW_RX, LCW_ACK, LCW_TX, LCW_TXACK} lcw_state_t;

	lcw_state_t state_q;
	lcw_state_t state_d;
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic [1:0] prev_q;
	logic [7:0] shift_q;
	logic [2:0] cnt_q;
	logic       done_q;
	logic       first_q;
	logic       matched_q;
	logic       rw_q;
	logic       ctrl_next_q;
	logic       co_q;
	logic       rs_q;
	logic       oe_n_q;
	logic [7:0] status_q;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic [7:0] rx_byte;
	logic       addr_hit;
	logic       data_byte;
	logic       ram_wr;
	logic       cmd_wr;
	logic       set_x;
	logic       set_y;
	logic       set_func;
	logic [7:0] tx_byte;

	// open-drain data output: only ever pulls low; the clock pin is never driven
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = oe_n_q;

	// two-flop synchronisers for clock, data and the address straps
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 4'hf;
			sync_q <= 4'hf;
			prev_q <= 2'h3;
		end else begin
			meta_q <= {addr_select_msb, addr_select_lsb, bus.sda_line, bus.scl};
			sync_q <= meta_q;
			prev_q <= sync_q[1:0];
		end
	end

	assign scl_s      = sync_q[0];
	assign sda_s      = sync_q[1];
	assign scl_rise   = scl_s & ~prev_q[0];
	assign scl_fall   = ~scl_s & prev_q[0];
	// a data edge while the clock stays high is a condition, not a bit
	assign start_cond = scl_s & prev_q[0] & prev_q[1] & ~sda_s;
	assign stop_cond  = scl_s & prev_q[0] & ~prev_q[1] & sda_s;
	assign rx_byte    = {shift_q[6:0], sda_s};
	// the straps fill the two low address bits
	assign addr_hit   = (shift_q[7:1] == {lcw_pkg::SLAVE_ADDR_HI, sync_q[3], sync_q[2]});

	// a byte completes on the eighth rising clock edge while receiving
	assign data_byte  = (state_q == LCW_RX) & scl_rise & (cnt_q == 3'h7) & ~first_q & ~ctrl_next_q & matched_q;
	assign ram_wr     = data_byte & rs_q;
	assign cmd_wr     = data_byte & ~rs_q;
	assign set_x      = cmd_wr & rx_byte[lcw_pkg::CMD_SETX_BIT];
	assign set_y      = cmd_wr & ~rx_byte[lcw_pkg::CMD_SETX_BIT] & rx_byte[lcw_pkg::CMD_SETY_BIT];
	assign set_func   = cmd_wr & ~rx_byte[lcw_pkg::CMD_SETX_BIT] & ~rx_byte[lcw_pkg::CMD_SETY_BIT] &
		rx_byte[lcw_pkg::CMD_FUNC_BIT];
	// read answer: temperature when select is clear, no ram read-back otherwise
	assign tx_byte    = rs_q ? lcw_pkg::NO_READBACK : status_q;

	// next state of the bit-level slave
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			LCW_IDLE: state_d = LCW_IDLE;
			LCW_RX: begin
				if (scl_fall && done_q) begin
					state_d = (matched_q || first_q) && (addr_hit || !first_q) ? LCW_ACK : LCW_IDLE;
				end
			end
			LCW_ACK: begin
				if (scl_fall) begin
					state_d = (rw_q && first_q) ? LCW_TX : LCW_RX;
				end
			end
			LCW_TX: begin
				if (scl_fall && cnt_q == 3'h7) begin
					state_d = LCW_TXACK;
				end
			end
			LCW_TXACK: begin
				if (scl_fall) begin
					state_d = done_q ? LCW_IDLE : LCW_TX;
				end
			end
		endcase
		// conditions override any bit in progress
		if (start_cond) begin
			state_d = LCW_RX;
		end else if (stop_cond) begin
			state_d = LCW_IDLE;
		end
	end

	// state, bit counter and shift register; reset puts the whole end idle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= LCW_IDLE;
			cnt_q   <= 3'h0;
			shift_q <= 8'h00;
			done_q  <= 1'b0;
			oe_n_q  <= 1'b1;
		end else begin
			state_q <= state_d;
			if (start_cond || stop_cond) begin
				cnt_q  <= 3'h0;
				done_q <= 1'b0;
				oe_n_q <= 1'b1;
			end else if (state_q == LCW_RX && scl_rise) begin
				shift_q <= rx_byte;
				cnt_q   <= 3'(cnt_q + 3'h1);
				done_q  <= (cnt_q == 3'h7);
			end else if (state_q == LCW_RX && state_d == LCW_ACK) begin
				oe_n_q  <= 1'b0;  // acknowledge low during the ninth clock
			end else if (state_q == LCW_ACK && state_d == LCW_TX) begin
				shift_q <= {tx_byte[6:0], 1'b0};
				oe_n_q  <= tx_byte[7];
				cnt_q   <= 3'h0;
				done_q  <= 1'b0;
			end else if (state_q == LCW_ACK && scl_fall) begin
				oe_n_q  <= 1'b1;
				done_q  <= 1'b0;
			end else if (state_q == LCW_TX && scl_fall) begin
				cnt_q   <= 3'(cnt_q + 3'h1);
				oe_n_q  <= (cnt_q == 3'h7) ? 1'b1 : shift_q[7];
				shift_q <= {shift_q[6:0], 1'b0};
			end else if (state_q == LCW_TXACK && scl_rise) begin
				done_q  <= sda_s;  // master not-acknowledge ends the read
			end else if (state_q == LCW_TXACK && state_d == LCW_TX) begin
				shift_q <= {tx_byte[6:0], 1'b0};
				oe_n_q  <= tx_byte[7];
				cnt_q   <= 3'h0;
			end
		end
	end

	// transfer context: address match, direction and control byte flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			first_q     <= 1'b0;
			matched_q   <= 1'b0;
			rw_q        <= 1'b0;
			ctrl_next_q <= 1'b1;
			co_q        <= 1'b0;
			rs_q        <= 1'b0;
		end else if (start_cond) begin
			first_q     <= 1'b1;
			matched_q   <= 1'b0;
			ctrl_next_q <= 1'b1;
		end else if (state_q == LCW_RX && scl_fall && done_q && first_q) begin
			matched_q <= addr_hit;
			rw_q      <= shift_q[0];
		end else if (state_q == LCW_ACK && scl_fall) begin
			first_q <= 1'b0;
		end else if (state_q == LCW_RX && scl_rise && cnt_q == 3'h7 && !first_q) begin
			if (ctrl_next_q) begin
				co_q        <= rx_byte[lcw_pkg::CTRL_CO_BIT];
				rs_q        <= rx_byte[lcw_pkg::CTRL_RS_BIT];
				ctrl_next_q <= 1'b0;
			end else begin
				ctrl_next_q <= co_q;  // cleared flag: only data follows
			end
		end
	end

	// addressing mode flags and the temperature status byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			horizontal_mirror_q <= 1'b0;
			vertical_q          <= 1'b0;
			status_q            <= lcw_pkg::TEMP_RESET;
		end else begin
			status_q <= temp_reading;
			if (set_func) begin
				horizontal_mirror_q <= rx_byte[lcw_pkg::FUNC_MX_BIT];
				vertical_q          <= rx_byte[lcw_pkg::FUNC_V_BIT];
			end
		end
	end

	// pointer values are trusted in range; out-of-range writes alias other cells
	lcw_ram_writer u_ram (
		.clk       (clk),
		.rst_b     (rst_b),
		.wr_en     (ram_wr),
		.wr_data   (rx_byte),
		.set_x     (set_x),
		.set_y     (set_y),
		.ptr_val   (rx_byte[6:0]),
		.mirror    (horizontal_mirror_q),
		.vertical  (vertical_q),
		.rd_bank   (disp_rd_bank),
		.rd_col    (disp_rd_col),
		.rd_data_q (disp_rd_data_q)
	);
endmodule // lcw_device

// ---- core/lcw_host.sv ----
// bus master end: byte-level requests turned into start, bits, acknowledge and stop
`timescale 1ns/10ps
module lcw_host #(
	parameter int QTR_CYC = lcw_pkg::SCL_QTR_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	lcw_if.host             bus,
	input  wire logic       req_valid,
	input  wire logic       req_start,
	input  wire logic       req_stop,
	input  wire logic       req_read,
	input  wire logic       req_nack,
	input  wire logic [7:0] req_byte,
	output logic            req_ready_q,
	output logic            rsp_valid_q,
	output logic      [7:0] rsp_byte_q,
	output logic            rsp_acked_q
);
	typedef enum logic [1:0] {LCH_IDLE, LCH_START, LCH_BITS, LCH_STOP} lch_state_t;

	lch_state_t state_q;
	logic [15:0] tick_q;
	logic [1:0]  ph_q;
	logic [3:0]  bit_q;
	logic [7:0]  sh_q;
	logic        scl_q;
	logic        oe_n_q;
	logic        rd_q;
	logic        nack_q;
	logic        stop_q;
	logic [1:0]  sda_sync_q;
	logic        qtr_end;
	logic        take;
	logic        bit_drive_n;

	assign bus.scl          = scl_q;
	assign bus.mst_sda_o    = 1'b0;
	assign bus.mst_sda_oe_n = oe_n_q;
	assign qtr_end          = (tick_q == 16'(QTR_CYC - 1));
	assign take             = req_valid & req_ready_q;
	// data bits: drive the byte when writing, release when reading; ninth bit is the reverse
	assign bit_drive_n      = (bit_q == 4'h8) ? (rd_q ? nack_q : 1'b1) : (rd_q ? 1'b1 : sh_q[7]);

	// quarter-period timer of the clock divider
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_q     <= 16'h0000;
			sda_sync_q <= 2'h3;
		end else begin
			tick_q     <= (state_q == LCH_IDLE || qtr_end) ? 16'h0000 : 16'(tick_q + 16'h0001);
			sda_sync_q <= {sda_sync_q[0], bus.sda_line};
		end
	end

	// sequencer: start only from a released bus, stop or hold after each byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q     <= LCH_IDLE;
			ph_q        <= 2'h0;
			bit_q       <= 4'h0;
			sh_q        <= 8'h00;
			scl_q       <= 1'b1;
			oe_n_q      <= 1'b1;
			rd_q        <= 1'b0;
			nack_q      <= 1'b0;
			stop_q      <= 1'b0;
			req_ready_q <= 1'b1;
			rsp_valid_q <= 1'b0;
			rsp_byte_q  <= 8'h00;
			rsp_acked_q <= 1'b0;
		end else begin
			rsp_valid_q <= 1'b0;
			if (state_q == LCH_IDLE) begin
				if (take) begin
					req_ready_q <= 1'b0;
					sh_q        <= req_byte;
					rd_q        <= req_read;
					nack_q      <= req_nack;
					stop_q      <= req_stop;
					bit_q       <= 4'h0;
					ph_q        <= 2'h0;
					state_q     <= req_start ? LCH_START : LCH_BITS;
				end
			end else if (qtr_end) begin
				ph_q <= 2'(ph_q + 2'h1);
				unique case (state_q)
					LCH_START: begin
						// release data, raise clock, then pull data low with clock high
						if (ph_q == 2'h1) begin
							scl_q <= 1'b1;
						end
						if (ph_q == 2'h2) begin
							oe_n_q <= 1'b0;
						end
						if (ph_q == 2'h0) begin
							oe_n_q <= 1'b1;
						end
						if (ph_q == 2'h3) begin
							state_q <= LCH_BITS;
						end
					end
					LCH_BITS: begin
						// data changes a quarter after the clock falls, never while high
						if (ph_q == 2'h0) begin
							scl_q <= 1'b0;
						end
						if (ph_q == 2'h1) begin
							oe_n_q <= bit_drive_n;
						end
						if (ph_q == 2'h2) begin
							scl_q <= 1'b1;
						end
						if (ph_q == 2'h3 && bit_q != 4'h8) begin
							sh_q  <= {sh_q[6:0], sda_sync_q[1]};
							bit_q <= 4'(bit_q + 4'h1);
						end
						if (ph_q == 2'h3 && bit_q == 4'h8) begin
							rsp_valid_q <= 1'b1;
							rsp_byte_q  <= sh_q;
							rsp_acked_q <= ~sda_sync_q[1];
							state_q     <= LCH_STOP;
						end
					end
					LCH_STOP: begin
						if (ph_q == 2'h0) begin
							scl_q <= 1'b0;
						end
						if (ph_q == 2'h1) begin
							oe_n_q <= ~stop_q;
						end
						if (ph_q == 2'h1 && !stop_q) begin
							state_q     <= LCH_IDLE;
							req_ready_q <= 1'b1;
						end
						if (ph_q == 2'h2) begin
							scl_q <= 1'b1;
						end
						if (ph_q == 2'h3) begin
							oe_n_q      <= 1'b1;
							state_q     <= LCH_IDLE;
							req_ready_q <= 1'b1;
						end
					end
					default: state_q <= LCH_IDLE;
				endcase
			end
		end
	end
endmodule // lcw_host

// ---- test/lcw_asserts.sv ----
// concurrent checks on the two-wire link between the master end and the lcd driver end
`timescale 1ns/10ps
module lcw_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic mst_sda_o,
	input wire logic mst_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic sda_line
);
	// one domain only, so clock and reset are stated once
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// release of reset must find the link idle with both ends let go
	a_reset_idle: assert property ($rose(rst_b) |-> scl && mst_sda_oe_n && dev_sda_oe_n)
		else $error("link not idle when reset is released");
	// both ends may only pull low; a high drive would fight the other end's pull
	a_dev_open_drain: assert property (!dev_sda_o && !mst_sda_o)
		else $error("an end drives a high level onto the data line");
	// device changes its pull only while the clock is low, else a bit becomes a condition
	a_dev_moves_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device end changed the data line while the clock was high");
	a_ack_after_fall: assert property ($fell(dev_sda_oe_n) |-> !scl && !$past(scl))
		else $error("device pull started without a clock low phase before it");
	a_ack_hold: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
		else $error("device pull dropped too early");
	// longest legal pull is an acknowledge followed by eight zero read bits
	a_ack_release: assert property ($fell(dev_sda_oe_n) |-> ##[16:320] dev_sda_oe_n)
		else $error("device pull never released");
	a_start_master: assert property ($fell(sda_line) && scl && $past(scl) |-> dev_sda_oe_n)
		else $error("device involved in a start condition");
	a_stop_quiet: assert property ($rose(sda_line) && scl && $past(scl) |-> dev_sda_oe_n [*5])
		else $error("device pulled the line after a stop condition");
endmodule // lcw_asserts

// ---- test/tb_lcd_ram_write_i2c_slave.sv ----
// self-checking bench: master end and lcd driver end joined across the two-wire link
`timescale 1ns/10ps
module tb_lcd_ram_write_i2c_slave;
	localparam int QTR = 8;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       req_valid, req_start, req_stop, req_read, req_nack;
	logic [7:0] req_byte;
	logic       req_ready_q, rsp_valid_q, rsp_acked_q;
	logic [7:0] rsp_byte_q;
	logic       sel_lsb, sel_msb, mirror_q, vert_q, mem_chk, mem_chk_d;
	logic [7:0] temp, rd_data_q;
	logic [4:0] rd_bank;
	logic [6:0] rd_col;
	logic [8:0] rsp_exp [$];
	logic [7:0] mem_exp [$];
	logic [7:0] exp_mem [int];
	int         mismatches, compares, cycles;
	int         seed = 32'h3d635cb5;
	wire  [6:0] dev_adr = {lcw_pkg::SLAVE_ADDR_HI, sel_msb, sel_lsb};

	always #(lcw_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

	lcw_if lcw_if_inst ();
	lcw_host #(.QTR_CYC(QTR)) lcw_host_inst (.clk(clk), .rst_b(rst_b), .bus(lcw_if_inst.host),
		.req_valid(req_valid), .req_start(req_start), .req_stop(req_stop), .req_read(req_read),
		.req_nack(req_nack), .req_byte(req_byte), .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
		.rsp_byte_q(rsp_byte_q), .rsp_acked_q(rsp_acked_q));
	lcw_device lcw_device_inst (.clk(clk), .rst_b(rst_b), .bus(lcw_if_inst.device),
		.addr_select_lsb(sel_lsb), .addr_select_msb(sel_msb), .temp_reading(temp), .disp_rd_bank(rd_bank),
		.disp_rd_col(rd_col), .disp_rd_data_q(rd_data_q), .horizontal_mirror_q(mirror_q), .vertical_q(vert_q));
	lcw_asserts lcw_asserts_inst (.clk(clk), .rst_b(rst_b), .scl(lcw_if_inst.scl),
		.mst_sda_o(lcw_if_inst.mst_sda_o), .mst_sda_oe_n(lcw_if_inst.mst_sda_oe_n),
		.dev_sda_o(lcw_if_inst.dev_sda_o), .dev_sda_oe_n(lcw_if_inst.dev_sda_oe_n),
		.sda_line(lcw_if_inst.sda_line));

	// every compare is counted; a miss is reported at once
	task automatic note(input logic ok, input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (!ok) begin
			mismatches++;
			$display("unexpected result at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_rsp(input logic [8:0] got, input logic [8:0] exp);
		note(got === exp, got, exp);
	endtask
	task automatic cmp_mem(input logic [7:0] got, input logic [7:0] exp);
		note(got === exp, {1'b0, got}, {1'b0, exp});
	endtask
	task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
		note(got === exp, {7'h00, got}, {7'h00, exp});
	endtask

	task automatic print_verdict();
		$display("counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one byte request held until the edge that takes it; expected answer noted first
	task automatic xfer(input logic st, input logic sp, input logic rd, input logic nk, input logic [7:0] b,
		input logic [8:0] exp);
		int n;
		n = 0;
		@(negedge clk);
		while (req_ready_q !== 1'b1 && n < 2000) begin
			n++;
			@(negedge clk);
		end
		{req_start, req_stop, req_read, req_nack, req_byte} = {st, sp, rd, nk, b};
		req_valid = 1'b1;
		rsp_exp.push_back(exp);
		@(negedge clk);
		req_valid = 1'b0;
	endtask
	task automatic wb(input logic st, input logic sp, input logic [7:0] b);
		xfer(st, sp, 1'b0, 1'b0, b, {1'b1, b});
	endtask

	// pointer and mode set by command words, then a random data stream; the bench tracks the pointer
	task automatic wr_frame(input int x, input int y, input logic v, input logic mx, input int n);
		logic [7:0] hdr [8];
		logic [7:0] d;
		hdr = '{{dev_adr, 1'b0}, 8'h80, {1'b1, x[6:0]}, 8'h80, {3'b010, y[4:0]}, 8'h80, {6'h08, v, mx}, 8'h40};
		foreach (hdr[i]) wb(i == 0, 1'b0, hdr[i]);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			wb(1'b0, i == n - 1, d);
			exp_mem[y * 101 + (mx ? 100 - x : x)] = (y == 16) ? {2'b00, d[5:0]} : d;
			if (v && y == 16) x = (x == 100) ? 0 : x + 1;
			if (v) y = (y == 16) ? 0 : y + 1;
			if (!v && x == 100) y = (y == 16) ? 0 : y + 1;
			if (!v) x = (x == 100) ? 0 : x + 1;
		end
		cmp_flag({mirror_q, vert_q}, {mx, v});
	endtask

	// display read port: address on one edge, data registered one cycle later
	task automatic rd_mem(input int k);
		@(negedge clk);
		rd_bank = 5'(k / 101);
		rd_col = 7'(k % 101);
		mem_exp.push_back(exp_mem[k]);
		mem_chk = 1'b1;
		@(negedge clk);
		mem_chk = 1'b0;
	endtask

	// watcher: oldest note against each result as it appears
	always @(posedge clk) begin
		mem_chk_d <= mem_chk;
		if (rsp_valid_q === 1'b1) cmp_rsp({rsp_acked_q, rsp_byte_q}, rsp_exp.pop_front());
		if (mem_chk_d === 1'b1) cmp_mem(rd_data_q, mem_exp.pop_front());
	end

	// hang guard, sized well above the expected run of about 24000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		{req_valid, req_start, req_stop, req_read, req_nack, mem_chk, sel_lsb, sel_msb} = '0;
		{req_byte, rd_bank, rd_col} = '0;
		temp = 8'($random(seed));
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		// each strap setting: own address answered, the one with both strap bits flipped and the byte after it not
		for (int s = 0; s < 4; s++) begin
			{sel_msb, sel_lsb} = s[1:0];
			repeat (4) @(negedge clk);
			wb(1'b1, 1'b1, {5'h0f, s[1:0], 1'b0});
			xfer(1'b1, 1'b0, 1'b0, 1'b0, {5'h0f, ~s[1:0], 1'b0}, {1'b0, 5'h0f, ~s[1:0], 1'b0});
			xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h40, 9'h040);
		end
		xfer(1'b1, 1'b1, 1'b0, 1'b0, {5'h1f, 2'b11, 1'b0}, {1'b0, 5'h1f, 2'b11, 1'b0});
		$display("test address_match done");
		// status read after select cleared, fixed answer after select set
		for (int rs = 0; rs < 2; rs++) begin
			temp = 8'($random(seed));
			wb(1'b1, 1'b0, {dev_adr, 1'b0});
			wb(1'b0, 1'b1, {1'b0, rs[0], 6'h00});
			wb(1'b1, 1'b0, {dev_adr, 1'b1});
			xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'hff, {1'b1, rs ? 8'hff : temp});
			xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'hff, {1'b0, rs ? 8'hff : temp});
		end
		$display("test status_read done");
		wr_frame(99, 16, 1'b0, 1'b0, 3);
		wr_frame(100, 3, 1'b0, 1'b0, 2);
		wr_frame(5, 15, 1'b1, 1'b0, 3);
		wr_frame(100, 16, 1'b1, 1'b1, 2);
		wr_frame(10, 7, 1'b0, 1'b1, 2);
		while (rsp_exp.size() != 0) @(negedge clk);
		$display("test ram_write done");
		// mid-run reset clears modes but leaves stored data alone
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		cmp_flag({mirror_q, vert_q}, 2'b00);
		cmp_mem(rd_data_q, 8'h00);
		rst_b = 1'b1;
		foreach (exp_mem[k]) rd_mem(k);
		repeat (4) @(negedge clk);
		$display("test ram_readback done");
		print_verdict();
	end
endmodule // tb_lcd_ram_write_i2c_slave
